// file: common/tsasp_map.svh
`ifndef TSASP_MAP_SVH
`define TSASP_MAP_SVH

// Field layout of the merged output word
`define TSASP_WORD_W       8
`define TSASP_NIB_W        4
`define TSASP_UPPER_MSB    7
`define TSASP_UPPER_LSB    4
`define TSASP_LOWER_MSB    3
`define TSASP_LOWER_LSB    0

// Comparator bank shape
`define TSASP_CMP_COUNT    15
`define TSASP_UPPER_SHIFT  4
`define TSASP_LOWER_SHIFT  8

// Analogue level resolution and reset values
`define TSASP_LEVEL_W      12
`define TSASP_WORD_RST     8'h00
`define TSASP_NIB_RST      4'h0

// Converter clock rises from sampling to word on the bus
`define TSASP_FILL_RISES   2'h3

`endif

// file: common/tsasp_pkg.sv
package tsasp_pkg;

	typedef logic [3:0] tsasp_nibble_type;
	typedef logic [7:0] tsasp_word_type;

	typedef enum logic {
		TSASP_BANK_A = 1'b0,
		TSASP_BANK_B = 1'b1
	} tsasp_bank_type;

endpackage : tsasp_pkg

// file: hw/tsasp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module tsasp_sync #(
	parameter int                 WIDTH   = 1,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// Asynchronous level in, synchronous level out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// Two flip-flops before any reader
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : tsasp_sync

`default_nettype wire

// file: hw/tsasp_cmp_bank.sv
`timescale 1ns/10ps
`default_nettype none

`include "tsasp_map.svh"

module tsasp_cmp_bank #(
	parameter int W     = `TSASP_LEVEL_W,
	parameter int SHIFT = `TSASP_UPPER_SHIFT
) (
	// Held sample and reference ladder
	input  wire logic [W-1:0] level,
	input  wire logic [W-1:0] base,
	input  wire logic [W-1:0] span,
	// Binary count of comparators tripped
	output var  logic [3:0]   code
);

	logic [`TSASP_CMP_COUNT-1:0] hit;
	logic [W+3:0]                level_ext;

	assign level_ext = {4'h0, level};

	// One threshold per comparator on the ladder
	genvar k;
	generate
		for (k = 1; k <= `TSASP_CMP_COUNT; k++) begin : g_cmp
			logic [W+3:0] prod;
			logic [W+3:0] thr;
			assign prod     = {4'h0, span} * 4'(k);
			assign thr      = {4'h0, base} + (prod >> SHIFT);
			assign hit[k-1] = (level_ext >= thr);
		end
	endgenerate

	// Thermometer to binary
	always_comb begin
		code = 4'h0;
		for (int i = 0; i < `TSASP_CMP_COUNT; i++) begin
			code = code + {3'h0, hit[i]};
		end
	end

endmodule : tsasp_cmp_bank

`default_nettype wire

// file: hw/tsasp_pipeline.sv
`timescale 1ns/10ps
`default_nettype none

`include "tsasp_map.svh"

module tsasp_pipeline
	import tsasp_pkg::*;
#(
	parameter int W = `TSASP_LEVEL_W
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	// Converter pins
	input  wire logic                     conv_clk_pin,
	input  wire logic                     oe_n_pin,
	// Analogue input and reference levels
	input  wire logic [W-1:0]             analog_level,
	input  wire logic [W-1:0]             top_reference_level,
	input  wire logic [W-1:0]             bottom_reference_level,
	// Output bus
	output var  tsasp_pkg::tsasp_word_type data_out,
	output var  logic                     data_oe,
	output var  logic                     word_valid,
	output var  logic                     word_strobe
);

	import tsasp_pkg::*;

	logic [1:0]       pins_s;
	logic [W-1:0]     level_s;
	logic [2*W-1:0]   refs_s;
	logic             conv_s;
	logic             oe_n_s;
	logic [W-1:0]     top_s;
	logic [W-1:0]     bot_s;
	logic             conv_prev_q;
	wire              fall;
	wire              rise;

	logic [W-1:0]     upper_samp_q;
	logic [W-1:0]     bank_samp_q [2];
	logic [W-1:0]     bank_ref_q [2];
	tsasp_bank_type   sel_q;
	tsasp_nibble_type upper_partial_result;
	tsasp_nibble_type upper_d1_q;
	tsasp_nibble_type lower_partial_result;
	tsasp_word_type   data_out_q;
	logic             data_oe_q;
	logic [1:0]       fill_q;
	logic             word_valid_q;
	logic             word_strobe_q;

	wire  [W-1:0]     span;
	tsasp_nibble_type upper_code;
	tsasp_nibble_type lower_code [2];
	wire  [W+3:0]     fref_prod;
	wire  [W-1:0]     fine_reference_level;
	wire              hold_bank;
	wire              fresh_bank;
	tsasp_nibble_type lower_sel;
	tsasp_word_type   merged;

	// Pin synchronisers
	tsasp_sync #(.WIDTH(2), .RST_VAL(2'h2)) u_sync_pins (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in ({oe_n_pin, conv_clk_pin}),
		.sync_out (pins_s)
	);

	tsasp_sync #(.WIDTH(W)) u_sync_level (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in (analog_level),
		.sync_out (level_s)
	);

	tsasp_sync #(.WIDTH(2*W)) u_sync_refs (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in ({top_reference_level, bottom_reference_level}),
		.sync_out (refs_s)
	);

	assign conv_s = pins_s[0];
	assign oe_n_s = pins_s[1];
	assign top_s  = refs_s[2*W-1:W];
	assign bot_s  = refs_s[W-1:0];

	assign fall = conv_prev_q & ~conv_s;
	assign rise = ~conv_prev_q & conv_s;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_prev_q <= 1'b0;
		end else begin
			conv_prev_q <= conv_s;
		end
	end

	// Ladder spans bottom to top reference
	assign span = top_s - bot_s;

	// Upper comparator bank, no missing codes
	tsasp_cmp_bank #(.W(W), .SHIFT(`TSASP_UPPER_SHIFT)) u_upper (
		.level (upper_samp_q),
		.base  (bot_s),
		.span  (span),
		.code  (upper_code)
	);

	// Fine reference picked by upper result
	assign fref_prod            = {4'h0, span} * {{W{1'b0}}, upper_code};
	assign fine_reference_level = bot_s + fref_prod[W+3:4];

	// Two lower banks, one per sample parity
	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_lower
			tsasp_cmp_bank #(.W(W), .SHIFT(`TSASP_LOWER_SHIFT)) u_lower (
				.level (bank_samp_q[b]),
				.base  (bank_ref_q[b]),
				.span  (span),
				.code  (lower_code[b])
			);
		end
	endgenerate

	// Bank sampled at the last fall, and the one still holding
	assign fresh_bank = ~sel_q;
	assign hold_bank  = sel_q;
	assign lower_sel  = lower_code[hold_bank];

	// Merge of upper and lower nibbles
	assign merged = {upper_d1_q, lower_partial_result};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_samp_q   <= '0;
			bank_samp_q[0] <= '0;
			bank_samp_q[1] <= '0;
		end else if (fall) begin
			upper_samp_q       <= level_s;
			bank_samp_q[sel_q] <= level_s;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q <= TSASP_BANK_A;
		end else if (fall) begin
			sel_q <= tsasp_bank_type'(~sel_q);
		end
	end

	// Upper result and fine reference on rise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_partial_result <= `TSASP_NIB_RST;
			upper_d1_q           <= `TSASP_NIB_RST;
			bank_ref_q[0]        <= '0;
			bank_ref_q[1]        <= '0;
		end else if (rise) begin
			upper_partial_result   <= upper_code;
			upper_d1_q             <= upper_partial_result;
			bank_ref_q[fresh_bank] <= fine_reference_level;
		end
	end

	// Lower result from the holding bank
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lower_partial_result <= `TSASP_NIB_RST;
		end else if (rise) begin
			lower_partial_result <= lower_sel;
		end
	end

	// Word out two rises after its sample's rise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out_q <= `TSASP_WORD_RST;
		end else if (rise) begin
			data_out_q <= merged;
		end
	end

	// Fill tracking, then one word per rise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_q        <= 2'h0;
			word_valid_q  <= 1'b0;
			word_strobe_q <= 1'b0;
		end else begin
			word_strobe_q <= rise & (fill_q == `TSASP_FILL_RISES);
			if (fall && fill_q != `TSASP_FILL_RISES) begin
				fill_q <= fill_q + 2'h1;
			end
			if (rise && fill_q == `TSASP_FILL_RISES) begin
				word_valid_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_oe_q <= 1'b0;
		end else begin
			data_oe_q <= ~oe_n_s;
		end
	end

	assign data_out    = data_out_q;
	assign data_oe     = data_oe_q;
	assign word_valid  = word_valid_q;
	assign word_strobe = word_strobe_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_sample_on_fall: assert property (
		fall |=> (upper_samp_q == $past(level_s)
			&& bank_samp_q[$past(sel_q)] == $past(level_s)))
		else $error("sample not taken on falling edge");

	a_bank_alternate: assert property (
		fall |=> (sel_q != $past(sel_q)))
		else $error("lower banks did not alternate");

	a_upper_on_rise: assert property (
		rise |=> (upper_partial_result == $past(upper_code)))
		else $error("upper result not settled on rise");

	a_lower_on_rise: assert property (
		rise |=> (lower_partial_result == $past(lower_code[sel_q])))
		else $error("lower result not from holding bank");

	a_merge_output: assert property (
		rise |=> (data_out_q == {$past(upper_d1_q),
			$past(lower_partial_result)}))
		else $error("merged word wrong");

	a_latency_edge: assert property (
		$changed(data_out_q) |-> $past(rise))
		else $error("bus changed off a rising edge");

	a_word_per_cycle: assert property (
		(word_valid_q && rise) |=> (word_strobe_q && word_valid_q))
		else $error("no word strobe after fill");

	a_bottom_code: assert property (
		(fall && level_s <= bot_s && top_s > bot_s)
			|=> (upper_code == 4'h0))
		else $error("bottom level not coded zero");

	a_oe_gate: assert property (
		$fell(oe_n_s) |=> data_oe_q)
		else $error("enable did not open bus");

endmodule : tsasp_pipeline

`default_nettype wire

// file: bench/tsasp_capture.sv
`timescale 1ns/10ps
`default_nettype none

module tsasp_capture
	import tsasp_pkg::*;
(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	// Frame control
	input  wire logic                      run,
	input  wire logic [3:0]                half_per,
	// Converter side
	output var  logic                      conv_clk_pin,
	input  wire tsasp_pkg::tsasp_word_type data_out,
	input  wire logic                      data_oe,
	input  wire logic                      word_strobe
);
	int             cyc;
	int             cnt;
	tsasp_word_type words[$];
	int             word_t[$];
	int             fall_t[$];

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc = 0;
			cnt = 0;
			conv_clk_pin <= 1'b0;
			words.delete();
			word_t.delete();
			fall_t.delete();
		end else begin
			cyc = cyc + 1;
			if (!run) begin
				cnt = 0;
				conv_clk_pin <= 1'b0;
			end else begin
				conv_clk_pin <= (cnt < int'(half_per));
				if (cnt == int'(half_per)) begin
					fall_t.push_back(cyc);
				end
				cnt = (cnt + 1) % (2 * int'(half_per));
			end
			if (word_strobe === 1'b1 && data_oe === 1'b1) begin
				words.push_back(data_out);
				word_t.push_back(cyc);
			end
		end
	end
endmodule : tsasp_capture

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import tsasp_pkg::*;
	logic           sys_clk;
	logic           reset_n;
	logic           oe_n_pin;
	logic           run;
	logic [3:0]     half_per;
	logic [11:0]    analog_level;
	logic [11:0]    lv[$];
	wire logic      conv_clk_pin;
	tsasp_word_type data_out;
	logic           data_oe;
	logic           word_valid;
	logic           word_strobe;
	int             err_total;
	int             tests_run;

	tsasp_pipeline #(.W(12)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.conv_clk_pin(conv_clk_pin), .oe_n_pin(oe_n_pin),
		.analog_level(analog_level), .top_reference_level(12'hF00),
		.bottom_reference_level(12'h000), .data_out(data_out),
		.data_oe(data_oe), .word_valid(word_valid),
		.word_strobe(word_strobe)
	);

	tsasp_capture u_cap (
		.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
		.half_per(half_per), .conv_clk_pin(conv_clk_pin),
		.data_out(data_out), .data_oe(data_oe),
		.word_strobe(word_strobe)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] exp_word(input logic [11:0] l);
		return (l >= 12'hF00) ? 8'hFF : 8'(l / 12'd15);
	endfunction : exp_word

	task automatic wait_conv(input logic lvl);
		int n;
		for (n = 0; n < 64 && conv_clk_pin !== lvl; n++) @(posedge sys_clk);
		if (n == 64) begin
			check("conv clock wait", 0, 1);
			print_verdict();
		end
	endtask : wait_conv

	task automatic run_stream(input int hp);
		int n;
		reset_n <= 1'b0;
		run <= 1'b0;
		half_per <= 4'(hp);
		repeat (10) @(posedge sys_clk);
		check("reset outputs", {data_out, data_oe, word_valid, word_strobe}, 0);
		reset_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		run <= 1'b1;
		foreach (lv[i]) begin
			wait_conv(1'b1);
			analog_level <= lv[i];
			wait_conv(1'b0);
			repeat (5) @(posedge sys_clk);
			analog_level <= ~lv[i];
		end
		for (n = 0; n < 400 && u_cap.words.size() < lv.size(); n++) begin
			@(posedge sys_clk);
		end
		run <= 1'b0;
		if (n == 400) begin
			check("word count", u_cap.words.size(), lv.size());
			print_verdict();
		end
		foreach (lv[i]) begin
			check("word", u_cap.words[i], exp_word(lv[i]));
			check("latency", u_cap.word_t[i] - u_cap.fall_t[i], 5 * hp + 4);
			if (i > 0) begin
				check("spacing", u_cap.word_t[i] - u_cap.word_t[i-1], 2 * hp);
			end
		end
		check("word valid", word_valid, 1);
	endtask : run_stream

	task automatic sweep_codes();
		lv.delete();
		for (int k = 0; k < 256; k++) lv.push_back(12'(k * 15));
		run_stream(8);
	endtask : sweep_codes

	task automatic edge_codes();
		lv = '{12'd14, 12'd15, 12'd1919, 12'd1920,
			12'd3839, 12'd3840, 12'hFFF, 12'd0};
		run_stream(12);
	endtask : edge_codes

	task automatic bus_enable();
		@(posedge sys_clk);
		oe_n_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 check("enable hold", data_oe, 1);
		@(posedge sys_clk);
		oe_n_pin <= 1'b0;
		#1 check("bus released", data_oe, 0);
		repeat (3) @(posedge sys_clk);
		#1 check("bus driven", data_oe, 1);
	endtask : bus_enable

	initial begin
		err_total = 0;
		tests_run = 0;
		reset_n = 1'b0;
		oe_n_pin = 1'b0;
		run = 1'b0;
		half_per = 4'h8;
		analog_level = 12'h000;
		sweep_codes();
		edge_codes();
		bus_enable();
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
